// File: logic/acc_pkg.sv
// Purpose: Constants for the analog comparator control block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   Byte offsets of own choosing, one word each
package acc_pkg;
    localparam int          AXI_AW           = 4;
    localparam logic [3:0]  ADDR_CTRL        = 4'h0;
    localparam logic [3:0]  ADDR_IRQ_STATUS  = 4'h4;
    localparam logic [3:0]  ADDR_IRQ_MASK    = 4'h8;
    localparam logic [3:0]  ADDR_POWER       = 4'hC;
    localparam int          BIT_ON           = 7;
    localparam int          BIT_REF_SEL      = 6;
    localparam int          BIT_FLAG         = 5;
    localparam int          BIT_IRQ_EN       = 4;
    localparam int          BIT_RESULT       = 3;
    localparam int          BIT_PIN_EN       = 2;
    localparam int          BIT_EDGE_HI      = 1;
    localparam int          BIT_EDGE_LO      = 0;
    localparam int          BIT_STOP3        = 0;
    localparam int          BIT_STOP2        = 1;
    localparam logic [7:0]  CTRL_RESET       = 8'h00;
    localparam logic [1:0]  EDGE_RISE        = 2'h1;
    localparam logic [1:0]  EDGE_BOTH        = 2'h3;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
    localparam int          SYNC_STAGES      = 3;
endpackage : acc_pkg

// File: logic/acc_sync.sv
// Purpose: Three-flop synchroniser with agreement filter
// Assumes: Asynchronous input, aclk domain
// Notes:   Output changes once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module acc_sync
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic async_in,
    output var  logic sync_out
);
    import acc_pkg::*;

    logic [2:0] stage_ff;
    logic [2:0] nxt_stage;
    logic       out_ff;
    logic       nxt_out;

    always_comb
    begin
        nxt_stage = {stage_ff[1:0], async_in};
        nxt_out   = (stage_ff[1] == stage_ff[2]) ? stage_ff[2] : out_ff;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stage_ff <= 3'h0;
            out_ff   <= 1'b0;
        end
        else
        begin
            stage_ff <= nxt_stage;
            out_ff   <= nxt_out;
        end
    end

    assign sync_out = out_ff;
endmodule : acc_sync
`default_nettype wire

// File: logic/acc_top.sv
// Purpose: Register and event logic around an analog comparator
// Assumes: Analog front end gives a raw result bit; AXI4-Lite slave
// Notes:   Control word at offset 0, low byte
`timescale 1ns/100ps
`default_nettype none
module acc_top
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [acc_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output var  logic                    s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output var  logic                    s_axi_wready,
    output var  logic [1:0]              s_axi_bresp,
    output var  logic                    s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [acc_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output var  logic                    s_axi_arready,
    output var  logic [31:0]             s_axi_rdata,
    output var  logic [1:0]              s_axi_rresp,
    output var  logic                    s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic                    raw_result,
    output var  logic                    comparator_on,
    output var  logic                    reference_select,
    output var  logic                    result_out_pin,
    output var  logic                    irq,
    output var  logic                    wake_request
);
    import acc_pkg::*;

    logic       aw_got_ff, nxt_aw_got;
    logic       w_got_ff, nxt_w_got;
    logic [3:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic       wstrb0_ff, nxt_wstrb0;
    logic       bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic       rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic       flag_ff, nxt_flag;
    logic       imask_ff, nxt_imask;
    logic [1:0] power_ff, nxt_power;
    logic       res_ff, nxt_res;
    logic       prev_ff, nxt_prev;
    logic       pin_ff, nxt_pin;
    logic       irq_ff, nxt_irq;
    logic       wake_ff, nxt_wake;
    logic       on_ff, nxt_on;
    logic       ref_ff, nxt_ref;
    logic       sync_res;
    logic       do_write;
    logic       wr_ctrl;
    logic       edge_hit;
    logic       live_res;

    // Raw result follows in the analog front end
    acc_sync u_sync
    (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (raw_result && on_ff),
        .sync_out (sync_res)
    );

    always_comb
    begin
        nxt_aw_got = aw_got_ff;
        nxt_w_got  = w_got_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata  = wdata_ff;
        nxt_wstrb0 = wstrb0_ff;
        if (s_axi_awvalid && !aw_got_ff)
        begin
            nxt_aw_got = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_ff)
        begin
            nxt_w_got  = 1'b1;
            nxt_wdata  = s_axi_wdata;
            nxt_wstrb0 = s_axi_wstrb[0];
        end
        do_write = aw_got_ff && w_got_ff && !bvalid_ff;
        if (do_write)
        begin
            nxt_aw_got = 1'b0;
            nxt_w_got  = 1'b0;
        end
        nxt_bvalid = bvalid_ff;
        nxt_bresp  = bresp_ff;
        if (do_write)
        begin
            nxt_bvalid = 1'b1;
            nxt_bresp  = (awaddr_ff[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            nxt_bvalid = 1'b0;
        end
        wr_ctrl = do_write && wstrb0_ff && (awaddr_ff == ADDR_CTRL);
    end

    // Register writes, stop2 reset and flag handling
    always_comb
    begin
        nxt_ctrl  = ctrl_ff;
        nxt_imask = imask_ff;
        nxt_power = power_ff;
        nxt_flag  = flag_ff;
        if (wr_ctrl)
        begin
            nxt_ctrl = wdata_ff[7:0];
        end
        if (do_write && wstrb0_ff && awaddr_ff == ADDR_IRQ_MASK)
        begin
            nxt_imask = wdata_ff[0];
        end
        if (do_write && wstrb0_ff && awaddr_ff == ADDR_POWER)
        begin
            nxt_power = wdata_ff[1:0];
        end
        if (wr_ctrl && wdata_ff[BIT_FLAG])
        begin
            nxt_flag = 1'b0;
        end
        if (do_write && wstrb0_ff && awaddr_ff == ADDR_IRQ_STATUS && wdata_ff[0])
        begin
            nxt_flag = 1'b0;
        end
        // Detect edge on synced result while enabled
        live_res = ctrl_ff[BIT_ON] && sync_res;
        unique case (ctrl_ff[BIT_EDGE_HI:BIT_EDGE_LO])
            EDGE_RISE: edge_hit = live_res && !prev_ff;
            EDGE_BOTH: edge_hit = live_res != prev_ff;
            default:   edge_hit = !live_res && prev_ff;
        endcase
        edge_hit = edge_hit && ctrl_ff[BIT_ON] && !power_ff[BIT_STOP2];
        if (edge_hit)
        begin
            nxt_flag = 1'b1;
        end
        nxt_prev = live_res;
        nxt_res  = live_res;
        if (power_ff[BIT_STOP2])
        begin
            nxt_ctrl = CTRL_RESET;
            nxt_flag = 1'b0;
            nxt_res  = 1'b0;
            nxt_prev = 1'b0;
        end
        nxt_on   = nxt_ctrl[BIT_ON];
        nxt_ref  = nxt_ctrl[BIT_REF_SEL];
        nxt_pin  = nxt_ctrl[BIT_PIN_EN] && nxt_res;
        nxt_irq  = nxt_flag && nxt_ctrl[BIT_IRQ_EN] && nxt_imask;
        nxt_wake = nxt_irq && power_ff[BIT_STOP3];
    end

    // Read channel
    always_comb
    begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (s_axi_arvalid && !rvalid_ff)
        begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = RESP_OKAY;
            nxt_rdata  = 32'h0000_0000;
            unique case (s_axi_araddr)
                ADDR_CTRL:
                    nxt_rdata = {24'h00_0000, ctrl_ff[7:6], flag_ff, ctrl_ff[4],
                                 res_ff, ctrl_ff[2:0]};
                ADDR_IRQ_STATUS: nxt_rdata = {31'h0000_0000, flag_ff};
                ADDR_IRQ_MASK:   nxt_rdata = {31'h0000_0000, imask_ff};
                ADDR_POWER:      nxt_rdata = {30'h0000_0000, power_ff};
                default:         nxt_rresp = RESP_SLVERR;
            endcase
        end
        else if (s_axi_rready)
        begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            awaddr_ff <= 4'h0;
            wdata_ff  <= 32'h0000_0000;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= RESP_OKAY;
            ctrl_ff   <= CTRL_RESET;
            flag_ff   <= 1'b0;
            imask_ff  <= 1'b1;
            power_ff  <= 2'h0;
            res_ff    <= 1'b0;
            prev_ff   <= 1'b0;
            pin_ff    <= 1'b0;
            irq_ff    <= 1'b0;
            wake_ff   <= 1'b0;
            on_ff     <= 1'b0;
            ref_ff    <= 1'b0;
        end
        else
        begin
            aw_got_ff <= nxt_aw_got;
            w_got_ff  <= nxt_w_got;
            awaddr_ff <= nxt_awaddr;
            wdata_ff  <= nxt_wdata;
            wstrb0_ff <= nxt_wstrb0;
            bvalid_ff <= nxt_bvalid;
            bresp_ff  <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
            ctrl_ff   <= nxt_ctrl;
            flag_ff   <= nxt_flag;
            imask_ff  <= nxt_imask;
            power_ff  <= nxt_power;
            res_ff    <= nxt_res;
            prev_ff   <= nxt_prev;
            pin_ff    <= nxt_pin;
            irq_ff    <= nxt_irq;
            wake_ff   <= nxt_wake;
            on_ff     <= nxt_on;
            ref_ff    <= nxt_ref;
        end
    end

    assign s_axi_awready    = !aw_got_ff;
    assign s_axi_wready     = !w_got_ff;
    assign s_axi_bvalid     = bvalid_ff;
    assign s_axi_bresp      = bresp_ff;
    assign s_axi_arready    = !rvalid_ff;
    assign s_axi_rvalid     = rvalid_ff;
    assign s_axi_rdata      = rdata_ff;
    assign s_axi_rresp      = rresp_ff;
    assign comparator_on    = on_ff;
    assign reference_select = ref_ff;
    assign result_out_pin   = pin_ff;
    assign irq              = irq_ff;
    assign wake_request     = wake_ff;

    // Assertions
    sequence rise_seen;
        ctrl_ff[BIT_ON] && ctrl_ff[BIT_EDGE_HI:BIT_EDGE_LO] == EDGE_RISE && !power_ff[BIT_STOP2]
            && sync_res && !prev_ff;
    endsequence

    flag_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rise_seen |=> flag_ff)
        else $error("flag missed a rising edge");
    flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_ctrl && wdata_ff[BIT_FLAG] && !edge_hit && !power_ff[BIT_STOP2]) |=> !flag_ff)
        else $error("flag not cleared by one");
    flag_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (flag_ff && !power_ff[BIT_STOP2] && !(do_write && wdata_ff[BIT_FLAG])
            && !(do_write && wdata_ff[0])) |=> flag_ff)
        else $error("flag lost without clear");
    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == (flag_ff && ctrl_ff[BIT_IRQ_EN] && imask_ff))
        else $error("irq level wrong");
    irq_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl_ff[BIT_IRQ_EN] |-> !irq || $past(ctrl_ff[BIT_IRQ_EN]))
        else $error("irq while disabled");
    res_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ctrl_ff[BIT_ON] ##1 !ctrl_ff[BIT_ON]) |-> !res_ff)
        else $error("result not zero while off");
    pin_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(!ctrl_ff[BIT_PIN_EN]) && !ctrl_ff[BIT_PIN_EN] |-> !result_out_pin)
        else $error("pin driven while disabled");
    stop2_rst_a: assert property (@(posedge aclk) disable iff (!aresetn)
        power_ff[BIT_STOP2] |=> ctrl_ff == CTRL_RESET && !flag_ff)
        else $error("stop2 did not reset");
    on_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
        comparator_on == ctrl_ff[BIT_ON])
        else $error("power enable mismatch");
endmodule : acc_top
`default_nettype wire

// File: testbench/acc_front_model.sv
// Purpose: Analog front end model for the comparator control block
// Assumes: Input voltages given as millivolt codes
// Notes:   Output holds the inverse of the last result while powered down
`timescale 1ns/100ps
`default_nettype none
module acc_front_model
#(
    parameter logic [11:0] BANDGAP_MV = 12'h04b0
)
(
    input  wire logic        on,
    input  wire logic        ref_sel,
    input  wire logic [11:0] plus_mv,
    input  wire logic [11:0] minus_mv,
    output var  logic        raw_result
);
    logic [11:0] non_inv;
    logic        last;
    initial last = 1'b0;
    always_comb non_inv = ref_sel ? BANDGAP_MV : plus_mv;
    always @(on or non_inv or minus_mv)
    begin
        if (on) last = (non_inv > minus_mv);
        raw_result = on ? last : ~last;
    end
endmodule : acc_front_model
`default_nettype wire

// File: testbench/tb_analog_comparator_control.sv
// Purpose: Self-checking bench for the comparator control block
// Assumes: AXI4-Lite master tasks, front end model
// Notes:   Random input levels from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module tb_analog_comparator_control;
    import acc_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [3:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic        awready, wready, bvalid, arready, rvalid, raw, on_o, ref_o, pin_o, irq_o, wake_o;
    logic [1:0]  bresp, rresp, resp;
    logic [11:0] plus_mv, minus_mv;
    logic [7:0]  cfg;
    logic        f;
    int          n_errors = 0;
    int          num_checks = 0;
    always #10 aclk = ~aclk;
    acc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .raw_result(raw), .comparator_on(on_o), .reference_select(ref_o),
        .result_out_pin(pin_o), .irq(irq_o), .wake_request(wake_o));
    acc_front_model FE (.on(on_o), .ref_sel(ref_o), .plus_mv(plus_mv), .minus_mv(minus_mv),
        .raw_result(raw));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end
        while (!bvalid && n < 50);
        resp = bresp;
        bready <= 1'b0;
        if (!bvalid) n_errors++;
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a);
        int n;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end
        while (!rvalid && n < 50);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (!rvalid) n_errors++;
    endtask : axi_rd
    task automatic drive_in(input logic hi);
        logic [11:0] m;
        logic [11:0] d;
        @(posedge aclk);
        m = 12'(($urandom % 3000) + 200);
        d = 12'(($urandom % 150) + 1);
        minus_mv <= m;
        plus_mv  <= hi ? m + d : m - d;
        repeat (10) @(posedge aclk);
    endtask : drive_in
    function automatic logic exp_flag(input logic [1:0] e, input logic rise);
        return rise ? (e == EDGE_RISE || e == EDGE_BOTH) : (e != EDGE_RISE);
    endfunction : exp_flag
    function automatic logic [31:0] exp_ctrl(input logic [7:0] c, input logic fl, input logic r);
        return {24'h00_0000, c[7:6], fl, c[4], r, c[2:0]};
    endfunction : exp_ctrl
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        report_and_stop();
    end
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, plus_mv, minus_mv} = '0;
        void'($urandom(32'h9f1e));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(ADDR_CTRL);
        chk(rd, {24'h00_0000, CTRL_RESET});
        drive_in(1'b0);
        for (int e = 0; e < 4; e++)
        begin
            cfg = 8'h94 | 8'(e);
            axi_wr(ADDR_CTRL, {24'h00_0000, cfg | 8'h20});
            for (int k = 1; k >= 0; k--)
            begin
                drive_in(k[0]);
                f = exp_flag(2'(e), k[0]);
                axi_rd(ADDR_CTRL);
                chk(rd, exp_ctrl(cfg, f, k[0]));
                chk({31'h0, pin_o}, {31'h0, k[0]});
                chk({31'h0, irq_o}, {31'h0, f});
                axi_wr(ADDR_CTRL, {24'h00_0000, cfg});
                axi_rd(ADDR_CTRL);
                chk(rd, exp_ctrl(cfg, f, k[0]));
                axi_wr(ADDR_CTRL, {24'h00_0000, cfg | 8'h20});
                axi_rd(ADDR_CTRL);
                chk(rd, exp_ctrl(cfg, 1'b0, k[0]));
            end
        end
        drive_in(1'b1);
        chk({31'h0, irq_o}, 32'h0000_0001);
        axi_wr(ADDR_IRQ_MASK, 32'h0000_0000);
        chk({31'h0, irq_o}, 32'h0000_0000);
        axi_wr(ADDR_IRQ_MASK, 32'h0000_0001);
        axi_wr(ADDR_POWER, 32'h0000_0001);
        repeat (3) @(posedge aclk);
        chk({31'h0, wake_o}, 32'h0000_0001);
        axi_wr(ADDR_POWER, 32'h0000_0000);
        axi_wr(ADDR_IRQ_STATUS, 32'h0000_0001);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq_o}, 32'h0000_0000);
        axi_wr(ADDR_CTRL, 32'h0000_0083);
        drive_in(1'b0);
        chk({31'h0, irq_o}, 32'h0000_0000);
        axi_wr(ADDR_CTRL, 32'h0000_00c0);
        @(posedge aclk);
        minus_mv <= 12'h0800;
        plus_mv  <= 12'h0fff;
        repeat (10) @(posedge aclk);
        axi_rd(ADDR_CTRL);
        chk({29'h0, ref_o, rd[BIT_REF_SEL], rd[BIT_RESULT]}, 32'h0000_0006);
        axi_wr(ADDR_CTRL, 32'h0000_0000);
        axi_rd(ADDR_CTRL);
        chk({30'h0, on_o, rd[BIT_RESULT]}, 32'h0000_0000);
        axi_wr(ADDR_CTRL, 32'h0000_0094);
        axi_wr(ADDR_POWER, 32'h0000_0002);
        axi_wr(ADDR_POWER, 32'h0000_0000);
        axi_rd(ADDR_CTRL);
        chk(rd, 32'h0000_0000);
        axi_wr(4'h1, 32'h0000_0080);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        axi_rd(ADDR_CTRL);
        chk(rd, 32'h0000_0000);
        report_and_stop();
    end
endmodule : tb_analog_comparator_control
`default_nettype wire
